// ---- inc/nvm_ctrl_pkg.sv ----
package nvm_ctrl_pkg;

  localparam int unsigned IO_AW = 6;
  localparam int unsigned DS_AW = 16;

  // Register offsets in the I/O space.
  localparam logic [5:0] CSR_OFS = 6'h32;
  localparam logic [5:0] CMD_OFS = 6'h33;
  localparam logic [5:0] PROT_OFS = 6'h3c;
  localparam logic [5:0] CMD_RESET = 6'h00;
  localparam int unsigned BUSY_BIT = 7;
  localparam int unsigned CMD_W = 6;

  localparam logic [7:0] PROT_KEY = 8'he7;
  localparam logic [2:0] PROT_WINDOW = 3'h4;

  localparam logic [5:0] CMD_NOP = 6'h00;
  localparam logic [5:0] CMD_CHIP_ERASE = 6'h10;
  localparam logic [5:0] CMD_CHIP_WRITE = 6'h11;
  localparam logic [5:0] CMD_SECTION_ERASE = 6'h14;
  localparam logic [5:0] CMD_PAGE_ERASE = 6'h18;
  localparam logic [5:0] CMD_WORD_WRITE = 6'h1d;

  // Data-space map: code selected by bits 15:10, small sections by bits 15:4.
  localparam int unsigned BYTE_SEL_BIT = 0;
  localparam int unsigned WORD_LSB = 1;
  localparam int unsigned WIP_MSB = 3;
  localparam int unsigned PAGE_MSB = 9;
  localparam int unsigned CODE_SEL_LSB = 10;
  localparam int unsigned SMALL_SEL_LSB = 4;
  localparam logic [5:0] CODE_SEL = 6'h10;
  localparam logic [11:0] LOCK_SEL = 12'h3f0;
  localparam logic [11:0] CFG_SEL = 12'h3f4;
  localparam logic [11:0] CAL_SEL = 12'h3f8;
  localparam logic [11:0] SIG_SEL = 12'h3fc;
  localparam logic [2:0] LOCK_WORD = 3'h0;

  localparam int unsigned CODE_WORDS = 512;
  localparam int unsigned CFG_WORDS = 4;
  localparam int unsigned WIDX_W = 9;
  localparam int unsigned WIP_W = 3;
  localparam int unsigned PAGE_WORDS = 8;
  localparam int unsigned CFG_IDX_W = 2;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Arbitrary contents of the read-only sections.
  localparam logic [15:0] SIG_WORD = 16'h5aa5;
  localparam logic [15:0] CAL_WORD = 16'hff80;

  // Cell timing, rounded up to whole clock cycles.
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WRITE_TIME_NS = 200;
  localparam int unsigned ERASE_TIME_NS = 800;
  localparam int unsigned LOCK_TIME_NS = 100;
  localparam logic [11:0] WRITE_CYCLES = 12'((WRITE_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] ERASE_CYCLES = 12'((ERASE_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] LOCK_CYCLES = 12'((LOCK_TIME_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ERASE_CODE = 3'b001,
    OP_ERASE_CFG = 3'b010,
    OP_ERASE_PAGE = 3'b011,
    OP_ERASE_LOCK = 3'b100,
    OP_WRITE_CODE = 3'b101,
    OP_WRITE_CFG = 3'b110,
    OP_WRITE_LOCK = 3'b111
  } mem_op_e;

  typedef enum logic [2:0] {
    SECT_NONE = 3'b000,
    SECT_CODE = 3'b001,
    SECT_CFG = 3'b010,
    SECT_SIG = 3'b011,
    SECT_CAL = 3'b100,
    SECT_LOCK = 3'b101
  } sect_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_LOCK_CLEAR = 2'b10
  } state_e;

endpackage

// ---- inc/nvm_mem_if.sv ----
interface nvm_mem_if;
  import nvm_ctrl_pkg::*;
  logic commit;
  mem_op_e op;
  logic [WIDX_W-1:0] wr_word;
  logic [15:0] wr_data;
  sect_e rd_sect;
  logic [WIDX_W-1:0] rd_word;
  logic [15:0] rd_data;
  modport ctrl(output commit, op, wr_word, wr_data, rd_sect, rd_word, input rd_data);
  modport mem(input commit, op, wr_word, wr_data, rd_sect, rd_word, output rd_data);
endinterface

// ---- logic/op_timer.sv ----
module op_timer (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic [11:0] i_cycles,
  output logic o_done
);
  logic [11:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= 12'h000;
      run_reg <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_reg <= i_cycles;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= 12'h001) begin
          run_reg <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 12'h001;
        end
      end
    end
  end
endmodule

// ---- logic/nvm_array.sv ----
module nvm_array
  import nvm_ctrl_pkg::*;
(
  input wire logic i_clk,
  nvm_mem_if.mem bus
);
  // Cell contents survive reset, so nothing here is reset.
  logic [15:0] code_mem [CODE_WORDS];
  logic [15:0] cfg_mem [CFG_WORDS];
  logic [7:0] lock_reg;

  // Programming only clears bits, so an unerased word ends up corrupted.
  always_ff @(posedge i_clk) begin
    if (bus.commit) begin
      unique case (bus.op)
        OP_ERASE_CODE: for (int i = 0; i < CODE_WORDS; i++) code_mem[i] <= ERASED_WORD;
        OP_ERASE_CFG: for (int i = 0; i < CFG_WORDS; i++) cfg_mem[i] <= ERASED_WORD;
        OP_ERASE_PAGE: begin
          for (int j = 0; j < PAGE_WORDS; j++) begin
            code_mem[{bus.wr_word[WIDX_W-1:WIP_W], WIP_W'(j)}] <= ERASED_WORD;
          end
        end
        OP_ERASE_LOCK: lock_reg <= ERASED_BYTE;
        OP_WRITE_CODE: code_mem[bus.wr_word] <= code_mem[bus.wr_word] & bus.wr_data;
        OP_WRITE_CFG: begin
          cfg_mem[bus.wr_word[CFG_IDX_W-1:0]] <= cfg_mem[bus.wr_word[CFG_IDX_W-1:0]] & bus.wr_data;
        end
        OP_WRITE_LOCK: lock_reg <= lock_reg & bus.wr_data[7:0];
        OP_NONE: ;
      endcase
    end
  end

  always_comb begin
    unique case (bus.rd_sect)
      SECT_CODE: bus.rd_data = code_mem[bus.rd_word];
      SECT_CFG: bus.rd_data = cfg_mem[bus.rd_word[CFG_IDX_W-1:0]];
      SECT_SIG: bus.rd_data = SIG_WORD;
      SECT_CAL: bus.rd_data = CAL_WORD;
      SECT_LOCK: bus.rd_data = {ERASED_BYTE, lock_reg};
      default: bus.rd_data = 16'h0000;
    endcase
  end
endmodule

// ---- logic/nvm_program_controller.sv ----
// The implementer's own choices: the placing of the registers and the strobed register port.
module nvm_program_controller
  import nvm_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [nvm_ctrl_pkg::IO_AW-1:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_we,
  input wire logic i_io_re,
  output logic [7:0] o_io_rdata,
  input wire logic [nvm_ctrl_pkg::DS_AW-1:0] i_ds_addr,
  input wire logic [7:0] i_ds_wdata,
  input wire logic i_ds_we,
  input wire logic i_ds_re,
  input wire logic i_cpu_access,
  output logic [7:0] o_ds_rdata,
  output logic o_ds_refused,
  input wire logic i_key_accepted,
  input wire logic i_prog_disable,
  output logic o_prog_enabled,
  output logic o_busy,
  output logic o_cpu_halt
);

  state_e state_reg;
  logic busy_reg;
  mem_op_e op_reg;
  mem_op_e trig_op;
  logic chip_reg;
  logic start_reg;
  logic [11:0] cyc_reg;
  logic [11:0] trig_cycles;
  logic [WIDX_W-1:0] wr_idx_reg;
  logic [15:0] wr_data_reg;
  logic [7:0] low_buf_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic [2:0] prot_cnt_reg;
  logic prog_en_reg;
  logic halt_reg;
  logic [7:0] io_rdata_reg;
  logic [7:0] ds_rdata_reg;
  logic refused_reg;
  logic tmr_done;
  logic op_end;
  logic access_ok;
  logic trig_ok;
  logic lo_load;
  logic rd_block;
  sect_e wr_sect;
  sect_e rd_sect;

  nvm_mem_if mem_bus();

  // Address decode shared by the read and the write path.
  function automatic sect_e sect_of(input logic [DS_AW-1:0] a);
    if (a[DS_AW-1:CODE_SEL_LSB] == CODE_SEL) begin
      return SECT_CODE;
    end else if (a[DS_AW-1:SMALL_SEL_LSB] == CFG_SEL) begin
      return SECT_CFG;
    end else if (a[DS_AW-1:SMALL_SEL_LSB] == CAL_SEL) begin
      return SECT_CAL;
    end else if (a[DS_AW-1:SMALL_SEL_LSB] == SIG_SEL) begin
      return SECT_SIG;
    end else if (a[DS_AW-1:SMALL_SEL_LSB] == LOCK_SEL && a[WIP_MSB:WORD_LSB] == LOCK_WORD) begin
      return SECT_LOCK;
    end
    return SECT_NONE;
  endfunction

  function automatic logic [WIDX_W-1:0] word_of(input logic [DS_AW-1:0] a);
    if (a[DS_AW-1:CODE_SEL_LSB] == CODE_SEL) begin
      return a[PAGE_MSB:WORD_LSB];
    end
    return WIDX_W'(a[WIP_MSB:WORD_LSB]);
  endfunction

  assign wr_sect = sect_of(i_ds_addr);
  assign rd_sect = wr_sect;

  always_comb begin
    trig_op = OP_NONE;
    case (cmd_reg)
      CMD_CHIP_ERASE: begin
        if (wr_sect == SECT_CODE) begin
          trig_op = OP_ERASE_CODE;
        end
      end
      CMD_SECTION_ERASE: begin
        if (wr_sect == SECT_CODE) begin
          trig_op = OP_ERASE_CODE;
        end else if (wr_sect == SECT_CFG) begin
          trig_op = OP_ERASE_CFG;
        end
      end
      CMD_WORD_WRITE, CMD_CHIP_WRITE: begin
        if (wr_sect == SECT_CODE) begin
          trig_op = OP_WRITE_CODE;
        end else if (wr_sect == SECT_CFG) begin
          trig_op = OP_WRITE_CFG;
        end else if (wr_sect == SECT_LOCK && cmd_reg == CMD_WORD_WRITE) begin
          trig_op = OP_WRITE_LOCK;
        end
      end
      CMD_PAGE_ERASE: begin
        if (wr_sect == SECT_CODE && i_cpu_access) begin
          trig_op = OP_ERASE_PAGE;
        end
      end
      default: trig_op = OP_NONE;
    endcase
    if (i_cpu_access && cmd_reg != CMD_WORD_WRITE && cmd_reg != CMD_PAGE_ERASE) begin
      trig_op = OP_NONE;
    end
  end

  always_comb begin
    unique case (trig_op)
      OP_ERASE_CODE, OP_ERASE_CFG, OP_ERASE_PAGE: trig_cycles = ERASE_CYCLES;
      OP_ERASE_LOCK: trig_cycles = LOCK_CYCLES;
      OP_WRITE_CODE, OP_WRITE_CFG, OP_WRITE_LOCK: trig_cycles = WRITE_CYCLES;
      OP_NONE: trig_cycles = WRITE_CYCLES;
    endcase
  end

  assign access_ok = i_cpu_access ? (prot_cnt_reg != 3'h0) : prog_en_reg;
  assign trig_ok = i_ds_we && i_ds_addr[BYTE_SEL_BIT] && !busy_reg && access_ok && trig_op != OP_NONE;
  assign lo_load = i_ds_we && !i_ds_addr[BYTE_SEL_BIT] && !busy_reg && (i_cpu_access || prog_en_reg);
  assign rd_block = busy_reg || (!i_cpu_access && !prog_en_reg);
  assign op_end = tmr_done && (state_reg == S_LOCK_CLEAR || (state_reg == S_EXEC && !chip_reg));

  op_timer u_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(start_reg),
    .i_cycles(cyc_reg),
    .o_done(tmr_done)
  );

  nvm_array u_array (
    .i_clk(i_clk),
    .bus(mem_bus)
  );

  assign mem_bus.commit = tmr_done && state_reg != S_IDLE;
  assign mem_bus.op = (state_reg == S_LOCK_CLEAR) ? OP_ERASE_LOCK : op_reg;
  assign mem_bus.wr_word = wr_idx_reg;
  assign mem_bus.wr_data = wr_data_reg;
  assign mem_bus.rd_sect = rd_sect;
  assign mem_bus.rd_word = word_of(i_ds_addr);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= S_IDLE;
      busy_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (trig_ok) begin
            state_reg <= S_EXEC;
            busy_reg <= 1'b1;
          end
        end
        S_EXEC: begin
          if (tmr_done && chip_reg) begin
            state_reg <= S_LOCK_CLEAR;
          end else if (tmr_done) begin
            state_reg <= S_IDLE;
            busy_reg <= 1'b0;
          end
        end
        S_LOCK_CLEAR: begin
          if (tmr_done) begin
            state_reg <= S_IDLE;
            busy_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      op_reg <= OP_NONE;
      chip_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_data_reg <= ERASED_WORD;
      start_reg <= 1'b0;
      cyc_reg <= WRITE_CYCLES;
    end else begin
      start_reg <= 1'b0;
      if (trig_ok) begin
        op_reg <= trig_op;
        chip_reg <= (cmd_reg == CMD_CHIP_ERASE);
        wr_idx_reg <= word_of(i_ds_addr);
        wr_data_reg <= {i_ds_wdata, low_buf_reg};
        start_reg <= 1'b1;
        cyc_reg <= trig_cycles;
      end else if (state_reg == S_EXEC && tmr_done && chip_reg) begin
        start_reg <= 1'b1;
        cyc_reg <= LOCK_CYCLES;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      low_buf_reg <= ERASED_BYTE;
    end else if (lo_load) begin
      low_buf_reg <= i_ds_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cmd_reg <= CMD_RESET;
    end else if (i_io_we && i_io_addr == CMD_OFS && !busy_reg) begin
      cmd_reg <= i_io_wdata[CMD_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prot_cnt_reg <= 3'h0;
    end else if (i_io_we && i_io_addr == PROT_OFS && i_io_wdata == PROT_KEY) begin
      prot_cnt_reg <= PROT_WINDOW;
    end else if (prot_cnt_reg != 3'h0) begin
      prot_cnt_reg <= prot_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prog_en_reg <= 1'b0;
    end else if (i_key_accepted) begin
      prog_en_reg <= 1'b1;
    end else if (i_prog_disable) begin
      prog_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      halt_reg <= 1'b0;
    end else if (trig_ok && i_cpu_access) begin
      halt_reg <= 1'b1;
    end else if (op_end) begin
      halt_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      io_rdata_reg <= 8'h00;
    end else begin
      io_rdata_reg <= 8'h00;
      if (i_io_re && i_io_addr == CSR_OFS) begin
        io_rdata_reg[BUSY_BIT] <= busy_reg;
      end else if (i_io_re && i_io_addr == CMD_OFS) begin
        io_rdata_reg <= {{(8 - CMD_W){1'b0}}, cmd_reg};
      end
    end
  end

  // A refused read answers zero so stale cell data never leaks mid-operation.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ds_rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      ds_rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
      if (i_ds_re && rd_block) begin
        refused_reg <= 1'b1;
      end else if (i_ds_re) begin
        ds_rdata_reg <= i_ds_addr[BYTE_SEL_BIT] ? mem_bus.rd_data[15:8] : mem_bus.rd_data[7:0];
      end
    end
  end

  assign o_io_rdata = io_rdata_reg;
  assign o_ds_rdata = ds_rdata_reg;
  assign o_ds_refused = refused_reg;
  assign o_prog_enabled = prog_en_reg;
  assign o_busy = busy_reg;
  assign o_cpu_halt = halt_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_busy_on_start: assert property (trig_ok |=> busy_reg && o_busy)
    else $error("busy not set after trigger");

  a_busy_until_end: assert property (busy_reg && !op_end |=> busy_reg)
    else $error("busy dropped before operation end");

  a_cmd_frozen: assert property (busy_reg && i_io_we && i_io_addr == CMD_OFS |=> $stable(cmd_reg))
    else $error("command changed while busy");

  a_read_blocked: assert property (i_ds_re && busy_reg |=> o_ds_refused && o_ds_rdata == 8'h00)
    else $error("read served while busy");

  a_read_byte_pick: assert property (i_ds_re && !rd_block && !i_ds_addr[BYTE_SEL_BIT]
    |=> o_ds_rdata == $past(mem_bus.rd_data[7:0]))
    else $error("low byte not returned");

  a_low_no_start: assert property (lo_load
    |=> !busy_reg && low_buf_reg == $past(i_ds_wdata))
    else $error("low byte write misbehaved");

  a_chip_lock_last: assert property (state_reg == S_EXEC && tmr_done && chip_reg
    |=> state_reg == S_LOCK_CLEAR && busy_reg)
    else $error("lock erase not chained after code erase");

  a_prot_closed: assert property (i_ds_we && i_cpu_access && prot_cnt_reg == 3'h0 && !busy_reg
    |=> !busy_reg)
    else $error("CPU trigger accepted without key");

  a_prot_window: assert property (i_io_we && i_io_addr == PROT_OFS && i_io_wdata == PROT_KEY
    |=> (prot_cnt_reg != 3'h0) [*4] ##1 (prot_cnt_reg == 3'h0 || $past(i_io_we)))
    else $error("protection window length wrong");

  a_cpu_filter: assert property (i_cpu_access && cmd_reg != CMD_WORD_WRITE && cmd_reg != CMD_PAGE_ERASE
    |-> !trig_ok)
    else $error("CPU ran a forbidden command");

  a_halt_on_cpu: assert property (trig_ok && i_cpu_access |=> o_cpu_halt throughout busy_reg [*2])
    else $error("CPU not halted");

  a_halt_release: assert property ($fell(busy_reg) |-> !o_cpu_halt)
    else $error("CPU still halted after busy cleared");

  c_chip_erase: cover property (state_reg == S_LOCK_CLEAR && tmr_done);
  c_word_write: cover property (trig_ok && trig_op == OP_WRITE_CODE);
  c_page_erase: cover property (trig_ok && trig_op == OP_ERASE_PAGE && i_cpu_access);
  c_refused: cover property (o_ds_refused);

endmodule

// ---- bench/host_model.sv ----
module host_model
  import nvm_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_io_rdata,
  input wire logic [7:0] i_ds_rdata,
  input wire logic i_ds_refused,
  output logic [nvm_ctrl_pkg::IO_AW-1:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  output logic o_io_we,
  output logic o_io_re,
  output logic [nvm_ctrl_pkg::DS_AW-1:0] o_ds_addr,
  output logic [7:0] o_ds_wdata,
  output logic o_ds_we,
  output logic o_ds_re,
  output logic o_cpu_access,
  output logic o_key_accepted,
  output logic o_prog_disable
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {o_io_addr, o_io_wdata, o_io_we, o_io_re} = '0;
    {o_ds_addr, o_ds_wdata, o_ds_we, o_ds_re} = '0;
    {o_cpu_access, o_key_accepted, o_prog_disable} = '0;
  end

  // Released write data and data-space addresses show inverted values so stale data never looks valid.
  task automatic io_wr(input logic [IO_AW-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_io_addr <= a;
    o_io_wdata <= d;
    o_io_we <= 1'b1;
    @(posedge i_clk);
    o_io_we <= 1'b0;
    o_io_wdata <= ~d;
    #1;
  endtask

  task automatic io_rd(input logic [IO_AW-1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_io_addr <= a;
    o_io_re <= 1'b1;
    @(posedge i_clk);
    o_io_re <= 1'b0;
    #1;
    d = i_io_rdata;
  endtask

  task automatic ds_wr(input logic [DS_AW-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_ds_addr <= a;
    o_ds_wdata <= d;
    o_ds_we <= 1'b1;
    @(posedge i_clk);
    o_ds_we <= 1'b0;
    o_ds_wdata <= ~d;
    o_ds_addr <= ~a;
    #1;
  endtask

  task automatic ds_rd(input logic [DS_AW-1:0] a, output logic [7:0] d, output logic r);
    @(posedge i_clk);
    o_ds_addr <= a;
    o_ds_re <= 1'b1;
    @(posedge i_clk);
    o_ds_re <= 1'b0;
    o_ds_addr <= ~a;
    #1;
    d = i_ds_rdata;
    r = i_ds_refused;
  endtask

  task automatic word(input logic [DS_AW-1:0] a, input logic [7:0] lo, input logic [7:0] hi);
    ds_wr(a, lo);
    ds_wr(a | 16'h0001, hi);
  endtask

  task automatic key();
    @(posedge i_clk);
    o_key_accepted <= 1'b1;
    @(posedge i_clk);
    o_key_accepted <= 1'b0;
    #1;
  endtask

  task automatic drop();
    @(posedge i_clk);
    o_prog_disable <= 1'b1;
    @(posedge i_clk);
    o_prog_disable <= 1'b0;
    #1;
  endtask

  task automatic set_cpu(input logic v);
    @(posedge i_clk);
    o_cpu_access <= v;
    #1;
  endtask

  // key, trigger after late idle cycles (in window only if late is small), two idle cycles.
  task automatic cpu_store(input logic [DS_AW-1:0] a, input int late);
    io_wr(PROT_OFS, PROT_KEY);
    repeat (late) @(posedge i_clk);
    ds_wr(a, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
  endtask
endmodule

// ---- bench/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_ctrl_pkg::*;

  logic clk, srst, io_we, io_re, ds_we, ds_re, cpu, key_acc, dis, refused, en, busy, halt, r;
  logic [IO_AW-1:0] io_addr;
  logic [DS_AW-1:0] ds_addr;
  logic [7:0] io_wdata, io_rdata, ds_wdata, ds_rdata, d;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0;

  nvm_program_controller nvm_program_controller_i (.i_clk(clk), .i_srst(srst), .i_io_addr(io_addr),
    .i_io_wdata(io_wdata), .i_io_we(io_we), .i_io_re(io_re), .o_io_rdata(io_rdata), .i_ds_addr(ds_addr),
    .i_ds_wdata(ds_wdata), .i_ds_we(ds_we), .i_ds_re(ds_re), .i_cpu_access(cpu), .o_ds_rdata(ds_rdata),
    .o_ds_refused(refused), .i_key_accepted(key_acc), .i_prog_disable(dis), .o_prog_enabled(en),
    .o_busy(busy), .o_cpu_halt(halt));

  host_model host_model_i (.i_clk(clk), .i_io_rdata(io_rdata), .i_ds_rdata(ds_rdata), .i_ds_refused(refused),
    .o_io_addr(io_addr), .o_io_wdata(io_wdata), .o_io_we(io_we), .o_io_re(io_re), .o_ds_addr(ds_addr),
    .o_ds_wdata(ds_wdata), .o_ds_we(ds_we), .o_ds_re(ds_re), .o_cpu_access(cpu), .o_key_accepted(key_acc),
    .o_prog_disable(dis));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A hung operation must still reach the closing report.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      $display("[ERR] timeout expected 0 seen 1");
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_idle(input int lo, input int hi);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("op_length", 8'h01, 8'((cyc - t0) >= lo && (cyc - t0) <= hi));
  endtask

  task automatic t_reset();
    host_model_i.io_rd(CMD_OFS, d);
    chk("cmd_reset", 8'h00, d);
    chk("busy_reset", 8'h00, {7'h0, busy});
    chk("en_reset", 8'h00, {7'h0, en});
    $display("test reset done");
  endtask

  task automatic t_config();
    host_model_i.key();
    chk("enabled", 8'h01, {7'h0, en});
    host_model_i.io_wr(CMD_OFS, 8'h14);
    host_model_i.ds_wr(16'h3f41, 8'h00);
    t0 = cyc;
    chk("cfg_erase_busy", 8'h01, {7'h0, busy});
    wait_idle(ERASE_CYCLES, ERASE_CYCLES + 6);
    host_model_i.io_wr(CMD_OFS, 8'h1d);
    host_model_i.word(16'h3f40, 8'hcd, 8'hab);
    t0 = cyc;
    wait_idle(WRITE_CYCLES, WRITE_CYCLES + 6);
    host_model_i.ds_rd(16'h3f40, d, r);
    chk("cfg_lo", 8'hcd, d);
    host_model_i.ds_rd(16'h3f41, d, r);
    chk("cfg_hi", 8'hab, d);
    $display("test config done");
  endtask

  task automatic t_chip();
    host_model_i.io_wr(CMD_OFS, 8'h10);
    host_model_i.ds_wr(16'h4001, 8'h00);
    t0 = cyc;
    chk("chip_busy", 8'h01, {7'h0, busy});
    host_model_i.io_rd(CSR_OFS, d);
    chk("csr_busy", 8'h80, d & 8'h80);
    host_model_i.io_wr(CMD_OFS, 8'h1d);
    host_model_i.ds_rd(16'h4000, d, r);
    chk("read_refused", 8'h01, {7'h0, r});
    chk("read_refused_data", 8'h00, d);
    wait_idle(ERASE_CYCLES + LOCK_CYCLES, ERASE_CYCLES + LOCK_CYCLES + 8);
    host_model_i.io_rd(CMD_OFS, d);
    chk("cmd_kept", 8'h10, d);
    host_model_i.ds_rd(16'h43ff, d, r);
    chk("code_top", ERASED_BYTE, d);
    host_model_i.ds_rd(16'h3f00, d, r);
    chk("lock_erased", ERASED_BYTE, d);
    host_model_i.ds_rd(16'h3f40, d, r);
    chk("cfg_untouched", 8'hcd, d);
    $display("test chip done");
  endtask

  task automatic t_word();
    host_model_i.io_wr(CMD_OFS, 8'h1d);
    host_model_i.ds_wr(16'h4010, 8'h34);
    chk("lo_only_idle", 8'h00, {7'h0, busy});
    host_model_i.ds_wr(16'h4011, 8'h12);
    t0 = cyc;
    chk("hi_starts", 8'h01, {7'h0, busy});
    wait_idle(WRITE_CYCLES, WRITE_CYCLES + 6);
    host_model_i.ds_rd(16'h4010, d, r);
    chk("word_lo", 8'h34, d);
    host_model_i.ds_rd(16'h4011, d, r);
    chk("word_hi", 8'h12, d);
    host_model_i.word(16'h3f00, 8'hfc, 8'h00);
    t0 = cyc;
    wait_idle(WRITE_CYCLES, WRITE_CYCLES + 6);
    host_model_i.ds_rd(16'h3f00, d, r);
    chk("lock_value", 8'hfc, d);
    host_model_i.io_wr(CMD_OFS, 8'h11);
    host_model_i.word(16'h3f00, 8'h00, 8'h00);
    chk("chip_write_no_lock", 8'h00, {7'h0, busy});
    host_model_i.ds_rd(16'h3f00, d, r);
    chk("lock_kept", 8'hfc, d);
    host_model_i.word(16'h4020, 8'h78, 8'h56);
    t0 = cyc;
    wait_idle(WRITE_CYCLES, WRITE_CYCLES + 6);
    host_model_i.ds_rd(16'h4021, d, r);
    chk("chip_write_hi", 8'h56, d);
    $display("test word done");
  endtask

  task automatic t_self();
    host_model_i.set_cpu(1'b1);
    host_model_i.io_wr(CMD_OFS, 8'h18);
    host_model_i.ds_wr(16'h4011, 8'h00);
    chk("no_key", 8'h00, {7'h0, busy});
    host_model_i.cpu_store(16'h4011, 5);
    chk("late_trigger", 8'h00, {7'h0, busy});
    host_model_i.cpu_store(16'h4011, 0);
    t0 = cyc - 2;
    chk("page_busy", 8'h01, {7'h0, busy});
    chk("cpu_halted", 8'h01, {7'h0, halt});
    wait_idle(ERASE_CYCLES, ERASE_CYCLES + 6);
    chk("cpu_released", 8'h00, {7'h0, halt});
    host_model_i.ds_rd(16'h4010, d, r);
    chk("page_erased", ERASED_BYTE, d);
    host_model_i.io_wr(CMD_OFS, 8'h10);
    host_model_i.cpu_store(16'h4001, 0);
    chk("cpu_chip_refused", 8'h00, {7'h0, busy});
    host_model_i.io_wr(CMD_OFS, 8'h14);
    host_model_i.cpu_store(16'h4001, 0);
    chk("cpu_sect_refused", 8'h00, {7'h0, busy});
    host_model_i.set_cpu(1'b0);
    $display("test self done");
  endtask

  task automatic t_exit();
    host_model_i.io_wr(CMD_OFS, 8'h14);
    host_model_i.ds_wr(16'h4001, 8'h00);
    t0 = cyc;
    wait_idle(ERASE_CYCLES, ERASE_CYCLES + 6);
    host_model_i.ds_rd(16'h4020, d, r);
    chk("code_sect_erased", ERASED_BYTE, d);
    host_model_i.drop();
    chk("disabled", 8'h00, {7'h0, en});
    host_model_i.io_wr(CMD_OFS, 8'h14);
    host_model_i.ds_wr(16'h4001, 8'h00);
    chk("locked_out", 8'h00, {7'h0, busy});
    $display("test exit done");
  endtask

  initial begin
    srst = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_chip();
    t_word();
    t_self();
    t_exit();
    end_of_test();
  end
endmodule
